// ===== gpio_pin_load.sv
// Model of the circuitry attached to the port pins
`timescale 1ns/1ps
module gpio_pin_load (
  input wire logic clk_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] pd_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] level_o
);
  logic [7:0] last_r = 8'h00; // Level of the previous cycle
  // Driver wins, then outside source, then resistor; a bare pin wanders
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) level_o[i] = out_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pu_i[i] | pd_i[i]) level_o[i] = pu_i[i];
      else level_o[i] = ~last_r[i];
    end
  end
  // Keep the level so a floating pin flips every cycle
  always_ff @(posedge clk_i) begin
    last_r <= level_o;
  end
endmodule : gpio_pin_load

// ===== gpio_port_defines.svh
// Register offsets, field positions and reset values for the port pin control block
// Summary of operation
// - Three-bit drive mode per pin, eight modes
// - Separate pin-state readback and output data registers
// - Digital high-Z: driver off, input enabled
// - Resistive modes: resistor one state, strong other
// - Open-drain: high-Z one value, strong other
// - Strong mode drives both levels from data
// - Combined pull: resistor up high, down low
// - Port and pin forms share configuration state
// - Per-pin register packs eight common bits
// - Output enable toggles high-Z input and mode
// - Sixteen routable output-enable lines to any pin
// - Slew select matters only strong/open-drain
// - One interrupt request line per port
// - Per-pin edge select: rise, fall, both, off
// - Edge sets status bit and raises request
// - Per-pin status register names the source
// - Edge detection keeps running in low power
// - Edge detection only, no level interrupts
// - Per-pin input buffer disable in any mode
// - Port threshold select, CMOS default, LVTTL alternative
// - Reset forces analog high-Z on every pin
// - Reset release loads stored reset configuration
// - Low power keeps pin drive state unchanged
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// Port-form register byte offsets
`define OFS_DRIVE0 8'h00
`define OFS_DRIVE1 8'h04
`define OFS_DRIVE2 8'h08
`define OFS_DATA 8'h0C
`define OFS_STATE 8'h10
`define OFS_SLEW 8'h14
`define OFS_INDIS 8'h18
`define OFS_BIDIR 8'h1C
`define OFS_CTL 8'h20
`define OFS_INTTYPE 8'h24
`define OFS_INTSTAT 8'h28
`define OFS_RSTCFG 8'h2C
`define OFS_OESEL 8'h30
`define OFS_PIN0 8'h40
// Per-pin register fields
`define PIN_DATA_BIT 0
`define PIN_STATE_BIT 1
`define PIN_DM_LO 2
`define PIN_SLEW_BIT 5
`define PIN_BIDIR_BIT 6
`define PIN_INDIS_BIT 7
// Control register fields
`define CTL_LVTTL_BIT 0
// Reset configuration encodings
`define RSTCFG_HIZ 2'h0
`define RSTCFG_PULLUP 2'h1
`define RSTCFG_PULLDN 2'h2

`endif

// ===== gpio_port_pin_control.sv
// Port pin control: drive modes, bidirectional enable, slew and edge interrupts
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "gpio_port_defines.svh"

module gpio_port_pin_control
  import gpio_port_pkg::*;
#(
  parameter int PINS = 8,
  parameter int OE_LINES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Stored nonvolatile reset configuration
  input wire logic [1:0] nv_rstcfg_i,
  // Output-enable lines from programmable logic
  input wire logic [OE_LINES-1:0] aux_oe_i,
  // Pads
  input wire logic [PINS-1:0] pad_in_i,
  output logic [PINS-1:0] pad_out_o,
  output logic [PINS-1:0] pad_oe_o,
  output logic [PINS-1:0] pad_pull_up_o,
  output logic [PINS-1:0] pad_pull_dn_o,
  output logic [PINS-1:0] pad_in_en_o,
  output logic [PINS-1:0] pad_fast_slew_o,
  output logic pad_lvttl_o,
  output logic port_irq_o
);

  // Refuse sizes the map cannot serve: one byte of pins per word,
  // four select bits per pin
  if (PINS < 1 || PINS > 8) begin : g_bad_pins
    $error("PINS must be 1..8");
  end
  if (OE_LINES < 1 || OE_LINES > 16) begin : g_bad_lines
    $error("OE_LINES must be 1..16");
  end

  // Configuration and status state; port and pin forms both land in the one-bit-per-pin drive, data, slew, input-disable and bidir fields
  logic [PINS-1:0] dm0_r; // Drive mode bit 0 per pin
  logic [PINS-1:0] dm1_r; // Drive mode bit 1 per pin
  logic [PINS-1:0] dm2_r; // Drive mode bit 2 per pin
  logic [PINS-1:0] data_r; // Output data value, never the pin level
  logic [PINS-1:0] slew_r; // Fast slew select
  logic [PINS-1:0] indis_r; // Input buffer disable
  logic [PINS-1:0] bidir_r; // Output enable taken from an auxiliary line
  logic lvttl_r; // Port threshold, low means CMOS
  logic [1:0] rstcfg_r; // Port reset configuration copy
  logic [3:0] oesel_r [PINS]; // Auxiliary line index per pin
  logic [PINS*2-1:0] inttype_r; // Edge type, two bits per pin
  logic [PINS-1:0] intstat_r; // Sticky edge status per pin
  logic load_rst_r; // High in the first cycle after reset
  // Synchroniser and edge history
  logic [PINS-1:0] sync1_r; // First stage, read by the second stage only
  logic [PINS-1:0] sync2_r; // Settled pin level
  logic [PINS-1:0] prev_r; // Settled level one cycle earlier
  logic [PINS-1:0] state_r; // Pin state readback
  // Bus decode
  logic wr_stb; // Write taken at this edge
  logic rd_stb; // Read taken at this edge
  logic [PINS-1:0] pin_hit; // Address selects this pin's register
  // Edge detection
  logic [PINS-1:0] rise; // Settled level went high
  logic [PINS-1:0] fall; // Settled level went low
  logic [PINS-1:0] edge_hit; // Edge of a configured kind
  logic [PINS-1:0] in_gate; // Input buffer passes the pin
  logic [31:0] rd_nxt; // Read word for the addressed register

  // A request counts once: ack blocks the second edge of a held cycle.
  // Writes without the low byte lane enabled are ignored

  assign wr_stb = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd_stb = cyc_i && stb_i && !we_i && !ack_o;

  // Per-pin register hit decode
  // Pin-form offsets are one word apart from the first pin register
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      assign pin_hit[g] = (adr_i == `OFS_PIN0 + 8'(4 * g));
      // Input buffer passes the pin only when enabled and not analog
      assign in_gate[g] = !indis_r[g] && ({dm2_r[g], dm1_r[g], dm0_r[g]} != DM_ANALOG_HIZ);
      // Configured edge match
      // Only settled levels are compared, never the raw pin
      assign rise[g] = sync2_r[g] && !prev_r[g];
      assign fall[g] = !sync2_r[g] && prev_r[g];
      assign edge_hit[g] = in_gate[g] &&
        ((rise[g] && (inttype_r[2*g+:2] == EDGE_RISE || inttype_r[2*g+:2] == EDGE_BOTH)) ||
         (fall[g] && (inttype_r[2*g+:2] == EDGE_FALL || inttype_r[2*g+:2] == EDGE_BOTH)));
    end
  endgenerate

  // Wishbone ack, one cycle after the strobe, dropped the next cycle
  // Registered answer: a held request is taken once, because ack blocks
  // the second edge and the master must drop stb before asking again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Reset-release load of the stored reset configuration
  // The stored value is sampled once, in the cycle after reset falls;
  // later writes only change the copy read back, not the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_rst_r <= 1'b1;
      rstcfg_r <= `RSTCFG_HIZ;
    end else begin
      load_rst_r <= 1'b0;
      if (load_rst_r) begin
        rstcfg_r <= nv_rstcfg_i;
      end else if (wr_stb && adr_i == `OFS_RSTCFG) begin
        rstcfg_r <= dat_i[1:0];
      end
    end
  end

  // Configuration writes, port form and pin form share state
  // Reset gives analog high-Z first, then the release load may pull the
  // whole port; a bus write in the load cycle, other than to OFS_OESEL, would be dropped,
  // so the master waits two edges after reset before its first request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Every pin held in analog high-Z
      dm0_r <= '0;
      dm1_r <= '0;
      dm2_r <= '0;
      data_r <= '0;
      slew_r <= '0;
      indis_r <= '0;
      bidir_r <= '0;
      lvttl_r <= 1'b0; // CMOS default
      inttype_r <= '0;
    end else if (load_rst_r) begin
      // A pull-up or pull-down reset state pulls the whole port
      if (nv_rstcfg_i == `RSTCFG_PULLUP) begin
        dm0_r <= '0;
        dm1_r <= '1;
        dm2_r <= '0;
        data_r <= '1;
      end else if (nv_rstcfg_i == `RSTCFG_PULLDN) begin
        dm0_r <= '1;
        dm1_r <= '1;
        dm2_r <= '0;
        data_r <= '0;
      end
    end else if (wr_stb) begin
      // State only changes by software, so it holds through low power
      case (adr_i)
        `OFS_DRIVE0: dm0_r <= dat_i[PINS-1:0];
        `OFS_DRIVE1: dm1_r <= dat_i[PINS-1:0];
        `OFS_DRIVE2: dm2_r <= dat_i[PINS-1:0];
        `OFS_DATA: data_r <= dat_i[PINS-1:0];
        `OFS_SLEW: slew_r <= dat_i[PINS-1:0];
        `OFS_INDIS: indis_r <= dat_i[PINS-1:0];
        `OFS_BIDIR: bidir_r <= dat_i[PINS-1:0];
        `OFS_CTL: lvttl_r <= dat_i[`CTL_LVTTL_BIT];
        `OFS_INTTYPE: inttype_r <= dat_i[PINS*2-1:0];
        default: begin
          // Pin form reaches the same bits as the port form
          for (int i = 0; i < PINS; i++) begin
            if (pin_hit[i]) begin
              data_r[i] <= dat_i[`PIN_DATA_BIT];
              dm0_r[i] <= dat_i[`PIN_DM_LO];
              dm1_r[i] <= dat_i[`PIN_DM_LO+1];
              dm2_r[i] <= dat_i[`PIN_DM_LO+2];
              slew_r[i] <= dat_i[`PIN_SLEW_BIT];
              bidir_r[i] <= dat_i[`PIN_BIDIR_BIT];
              indis_r[i] <= dat_i[`PIN_INDIS_BIT];
            end
          end
        end
      endcase
    end
  end

  // Output-enable line selection per pin, nibble per pin
  // Index values beyond the implemented lines wrap, so no select is
  // ever left pointing at a line that does not exist
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PINS; i++) oesel_r[i] <= 4'h0;
    end else if (wr_stb && adr_i == `OFS_OESEL) begin
      for (int i = 0; i < PINS; i++) oesel_r[i] <= dat_i[4*i+:4];
    end
  end

  // Two-stage synchroniser, then history for edge compare
  // The pin is asynchronous to the system clock: only sync2_r and prev_r
  // feed logic, sync1_r is read by the second stage alone so that a
  // metastable first stage has a whole cycle to settle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= pad_in_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Pin state readback, gated by the input buffer
  // Readback lags the pin by three edges; a disabled or analog
  // input reads 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= sync2_r & in_gate;
    end
  end

  // Sticky status, edge set wins over read clear
  // Reading the status returns the old bits and clears them, but an
  // edge in the same cycle is kept, so no event is lost between the
  // read and the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intstat_r <= '0;
    end else if (rd_stb && adr_i == `OFS_INTSTAT) begin
      intstat_r <= edge_hit;
    end else begin
      intstat_r <= intstat_r | edge_hit;
    end
  end

  // One request line for the whole port
  // Includes the arriving edge so the request is not a cycle behind
  // the status; it stays up until software reads the status register,
  // and since only edges set status, a held level raises it once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_irq_o <= 1'b0;
    end else begin
      port_irq_o <= |(intstat_r | edge_hit);
    end
  end

  // Read multiplexer
  // Unmapped offsets read zero; every writable field reads back
  always_comb begin
    rd_nxt = 32'h0;
    case (adr_i)
      `OFS_DRIVE0: rd_nxt[PINS-1:0] = dm0_r;
      `OFS_DRIVE1: rd_nxt[PINS-1:0] = dm1_r;
      `OFS_DRIVE2: rd_nxt[PINS-1:0] = dm2_r;
      `OFS_DATA: rd_nxt[PINS-1:0] = data_r;
      `OFS_STATE: rd_nxt[PINS-1:0] = state_r;
      `OFS_SLEW: rd_nxt[PINS-1:0] = slew_r;
      `OFS_INDIS: rd_nxt[PINS-1:0] = indis_r;
      `OFS_BIDIR: rd_nxt[PINS-1:0] = bidir_r;
      `OFS_CTL: rd_nxt[`CTL_LVTTL_BIT] = lvttl_r;
      `OFS_INTTYPE: rd_nxt[PINS*2-1:0] = inttype_r;
      `OFS_INTSTAT: rd_nxt[PINS-1:0] = intstat_r;
      `OFS_RSTCFG: rd_nxt[1:0] = rstcfg_r;
      `OFS_OESEL: begin
        for (int i = 0; i < PINS; i++) rd_nxt[4*i+:4] = oesel_r[i];
      end
      default: begin
        // Pin form gathers one pin's common bits in one word
        for (int i = 0; i < PINS; i++) begin
          if (pin_hit[i]) begin
            rd_nxt[`PIN_DATA_BIT] = data_r[i];
            rd_nxt[`PIN_STATE_BIT] = state_r[i];
            rd_nxt[`PIN_DM_LO+:3] = {dm2_r[i], dm1_r[i], dm0_r[i]};
            rd_nxt[`PIN_SLEW_BIT] = slew_r[i];
            rd_nxt[`PIN_BIDIR_BIT] = bidir_r[i];
            rd_nxt[`PIN_INDIS_BIT] = indis_r[i];
          end
        end
      end
    endcase
  end

  // Read data register, held until the next read
  // Loaded at the edge that raises ack, so it stands while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (rd_stb) begin
      dat_o <= rd_nxt;
    end
  end

  // Pad drive decode per pin
  // Bidirectional pins fall back to digital high-Z while their line is
  // low; slew only reaches the pad in strong and open-drain modes, the
  // resistive modes ignore it; the resistor and the strong driver are
  // never on together, so a pin never fights its own pull
  pad_ctl_s pad_nxt [PINS];
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      logic [2:0] dm;
      logic d;
      logic oe_sel;
      dm = {dm2_r[i], dm1_r[i], dm0_r[i]};
      d = data_r[i];
      oe_sel = aux_oe_i[oesel_r[i] % OE_LINES];
      // Bidirectional: deasserted enable gives digital high-Z
      if (bidir_r[i] && !oe_sel) dm = DM_DIGITAL_HIZ;
      pad_nxt[i] = '0;
      pad_nxt[i].out = d;
      pad_nxt[i].in_en = (dm != DM_ANALOG_HIZ) && !indis_r[i];
      case (dm)
        DM_ANALOG_HIZ, DM_DIGITAL_HIZ: pad_nxt[i].oe = 1'b0;
        DM_PULL_UP: begin
          pad_nxt[i].oe = !d;
          pad_nxt[i].pull_up = d;
        end
        DM_PULL_DOWN: begin
          pad_nxt[i].oe = d;
          pad_nxt[i].pull_dn = !d;
        end
        DM_OD_LOW: begin
          pad_nxt[i].oe = !d;
          pad_nxt[i].fast_slew = slew_r[i];
        end
        DM_OD_HIGH: begin
          pad_nxt[i].oe = d;
          pad_nxt[i].fast_slew = slew_r[i];
        end
        DM_STRONG: begin
          pad_nxt[i].oe = 1'b1;
          pad_nxt[i].fast_slew = slew_r[i];
        end
        DM_PULL_BOTH: begin
          pad_nxt[i].oe = 1'b0;
          pad_nxt[i].pull_up = d;
          pad_nxt[i].pull_dn = !d;
        end
        default: pad_nxt[i].oe = 1'b0;
      endcase
    end
  end

  // Registered pad outputs
  // Registered so the pads never glitch while several fields of one
  // pin change at once; reset holds every pin in analog high-Z, and
  // low-power modes leave these flip-flops untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o <= '0;
      pad_oe_o <= '0;
      pad_pull_up_o <= '0;
      pad_pull_dn_o <= '0;
      pad_in_en_o <= '0;
      pad_fast_slew_o <= '0;
      pad_lvttl_o <= 1'b0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        pad_out_o[i] <= pad_nxt[i].out;
        pad_oe_o[i] <= pad_nxt[i].oe;
        pad_pull_up_o[i] <= pad_nxt[i].pull_up;
        pad_pull_dn_o[i] <= pad_nxt[i].pull_dn;
        pad_in_en_o[i] <= pad_nxt[i].in_en;
        pad_fast_slew_o[i] <= pad_nxt[i].fast_slew;
      end
      pad_lvttl_o <= lvttl_r;
    end
  end

endmodule : gpio_port_pin_control

// ===== gpio_port_pin_control_assertions.sv
// Port-level checks for the port pin control block
`timescale 1ns/1ps
module gpio_port_pin_control_chk #(
  parameter int PINS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic [PINS-1:0] pad_out_o,
  input wire logic [PINS-1:0] pad_oe_o,
  input wire logic [PINS-1:0] pad_pull_up_o,
  input wire logic [PINS-1:0] pad_pull_dn_o,
  input wire logic [PINS-1:0] pad_in_en_o,
  input wire logic [PINS-1:0] pad_fast_slew_o,
  input wire logic pad_lvttl_o,
  input wire logic port_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus request taken at this edge
  wire logic req = cyc_i & stb_i & ~ack_o;
  // Pins with a resistor enabled
  wire logic [PINS-1:0] pulled = pad_pull_up_o | pad_pull_dn_o;
  chk_ack_next: assert property (req |=> ack_o) else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i & stb_i)) else $error("stray ack");
  chk_reset_hiz: assert property (disable iff (1'b0) rst_i |=>
      (pad_oe_o | pulled | pad_in_en_o) == '0) else $error("pin driven in reset");
  chk_drive_excl: assert property ((pad_oe_o & pulled) == '0)
      else $error("driver and resistor together");
  chk_pull_level: assert property (((pad_pull_up_o & ~pad_out_o) |
      (pad_pull_dn_o & pad_out_o)) == '0) else $error("resistor against data");
  chk_slew_resist: assert property ((pad_fast_slew_o & pulled) == '0)
      else $error("fast slew in resistive mode");
  chk_irq_clear: assert property ($fell(port_irq_o) |->
      ack_o || $past(ack_o) || $past(ack_o, 2)) else $error("irq dropped unread");
  chk_lvttl_wr: assert property (req && we_i && sel_i[0] && adr_i == 8'h20 |=>
      ##1 pad_lvttl_o == $past(dat_i[0], 2)) else $error("threshold not written");
  chk_lvttl_hold: assert property ($changed(pad_lvttl_o) |-> $past(ack_o))
      else $error("threshold moved unasked");
  // Main scenarios
  cover property (ack_o && we_i);
  cover property ($rose(port_irq_o));
  cover property (pad_lvttl_o);
endmodule : gpio_port_pin_control_chk

bind gpio_port_pin_control gpio_port_pin_control_chk #(.PINS(PINS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .pad_pull_up_o(pad_pull_up_o), .pad_pull_dn_o(pad_pull_dn_o),
  .pad_in_en_o(pad_in_en_o), .pad_fast_slew_o(pad_fast_slew_o),
  .pad_lvttl_o(pad_lvttl_o), .port_irq_o(port_irq_o));

// ===== gpio_port_pin_control_tb.sv
// Self-checking bench for the port pin control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module gpio_port_pin_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] sel_i = 4'hF; // Byte lanes of a write
  logic ack_o;
  logic pad_lvttl_o;
  logic port_irq_o;
  logic [7:0] adr_i = 8'h00;
  logic [7:0] ext_en = 8'h00; // Outside source drives these pins
  logic [7:0] ext_val = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic [1:0] nv_rstcfg_i = 2'h1; // Stored config: pull-up
  logic [15:0] aux_oe_i = 16'h0000;
  logic [7:0] pad_in, pad_out_o, pad_oe_o, pad_pull_up_o, pad_pull_dn_o;
  logic [7:0] pad_in_en_o, pad_fast_slew_o;
  int fails = 0;
  int n_compared = 0;
  always #20 clk_i = ~clk_i;
  gpio_port_pin_control dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .nv_rstcfg_i(nv_rstcfg_i), .aux_oe_i(aux_oe_i), .pad_in_i(pad_in),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pull_up_o(pad_pull_up_o),
    .pad_pull_dn_o(pad_pull_dn_o), .pad_in_en_o(pad_in_en_o),
    .pad_fast_slew_o(pad_fast_slew_o), .pad_lvttl_o(pad_lvttl_o), .port_irq_o(port_irq_o));
  gpio_pin_load u_load (.clk_i(clk_i), .out_i(pad_out_o), .oe_i(pad_oe_o),
    .pu_i(pad_pull_up_o), .pd_i(pad_pull_dn_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .level_o(pad_in));
  // Verdict and end of run
  task automatic final_report();
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 20);
    if (i >= 20) begin
      fails++;
      final_report();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Every mode and data value on pin 0, fast slew set, reaching the pad only in open-drain and strong modes
  task automatic t_modes();
    logic [3:0] e;
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        e[3] = m == 6 || ((m == 2 || m == 4) && d == 0) || ((m == 3 || m == 5) && d == 1);
        e[2] = d == 1 && (m == 2 || m == 7);
        e[1] = d == 0 && (m == 3 || m == 7);
        e[0] = m != 0;
        // No pin runs at a regulated level, so resistive codes are legal
        wb(1'b1, 8'h40, 32'h20 | (m << 2) | d);
        `CHK("drive", e, {pad_oe_o[0], pad_pull_up_o[0], pad_pull_dn_o[0], pad_in_en_o[0]})
        `CHK("slew", m >= 4 && m <= 6, pad_fast_slew_o[0])
      end
    end
  endtask : t_modes
  // Edge on pins, then status read, clear and pin state
  task automatic t_edge(input logic [7:0] v, input logic [7:0] st, input logic [7:0] ps);
    int i;
    i = 0;
    ext_val <= v;
    while (port_irq_o !== 1'b1 && i < 20) begin
      @(posedge clk_i);
      i++;
    end
    if (i >= 20) begin
      fails++;
      final_report();
    end
    `CHK("irq", st != 0, port_irq_o)
    tick(2);
    wb(1'b0, 8'h28, 32'h0);
    `CHK("status", {24'h0, st}, rd)
    wb(1'b0, 8'h10, 32'h0);
    `CHK("state", {24'h0, ps}, rd)
    wb(1'b0, 8'h28, 32'h0);
    `CHK("status clear", 32'h0, rd)
    `CHK("irq clear", 1'b0, port_irq_o)
  endtask : t_edge
  // Reset in mid-run with a pull-down stored configuration
  task automatic t_reset_pulldn();
    rst_i <= 1'b1;
    nv_rstcfg_i <= 2'h2;
    tick(2);
    `CHK("mid reset pads", 16'h0, {pad_oe_o, pad_pull_up_o})
    rst_i <= 1'b0;
    tick(3);
    `CHK("pull-down load", 24'hFF0000, {pad_pull_dn_o, pad_pull_up_o, pad_out_o})
    `CHK("threshold reset", 1'b0, pad_lvttl_o)
    wb(1'b0, 8'h2C, 32'h0);
    `CHK("reset config", 32'h2, rd)
  endtask : t_reset_pulldn
  initial begin
    tick(16);
    `CHK("reset pads", 32'h0, {pad_oe_o, pad_pull_up_o, pad_pull_dn_o, pad_in_en_o})
    rst_i <= 1'b0;
    tick(3);
    `CHK("reset load", 16'hFFFF, {pad_pull_up_o, pad_out_o})
    t_modes();
    ext_en <= 8'hFF;
    wb(1'b1, 8'h00, 32'hFF);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b0, 8'h44, 32'h0);
    `CHK("pin form", 8'h05, rd[7:0] & 8'hFD)
    `CHK("digital hiz", 16'hFF00, {pad_in_en_o, pad_oe_o})
    wb(1'b1, 8'h24, 32'hE4);
    tick(8);
    wb(1'b0, 8'h28, 32'h0);
    t_edge(8'h0F, 8'h0A, 8'h0F);
    t_edge(8'h00, 8'h0C, 8'h00);
    wb(1'b1, 8'h18, 32'h08);
    t_edge(8'h0F, 8'h02, 8'h07);
    wb(1'b1, 8'h30, 32'h9);
    wb(1'b1, 8'h40, 32'h59);
    aux_oe_i <= 16'hFDFF;
    tick(3);
    `CHK("bidir off", 3'b010, {pad_oe_o[0], pad_in_en_o[0], pad_pull_up_o[0]})
    aux_oe_i <= 16'h0200;
    tick(3);
    `CHK("bidir on", 2'b11, {pad_oe_o[0], pad_out_o[0]})
    `CHK("lvttl off", 1'b0, pad_lvttl_o)
    wb(1'b1, 8'h20, 32'h1);
    `CHK("lvttl on", 1'b1, pad_lvttl_o)
    sel_i <= 4'h0;
    wb(1'b1, 8'h20, 32'h0);
    `CHK("lvttl lane off", 1'b1, pad_lvttl_o)
    sel_i <= 4'hF;
    wb(1'b0, 8'hFC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    t_reset_pulldn();
    final_report();
  end
endmodule : gpio_port_pin_control_tb

// ===== gpio_port_pkg.sv
// Types shared by the port pin control block
package gpio_port_pkg;
  // Drive mode codes in documented order
  typedef enum logic [2:0] {
    DM_ANALOG_HIZ, DM_DIGITAL_HIZ, DM_PULL_UP, DM_PULL_DOWN,
    DM_OD_LOW, DM_OD_HIGH, DM_STRONG, DM_PULL_BOTH
  } drive_mode_e;
  // Edge selection per pin
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_e;
  // Pad control for one pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_dn;
    logic in_en;
    logic fast_slew;
  } pad_ctl_s;
endpackage : gpio_port_pkg
